/* logic/per_pkg.sv */
// Purpose: Shared constants and types of the PCI/PCI-X error-response block
// Assumes: All counts are in bus clocks of core_clk
// Notes: Status bit positions follow the command and status register layouts
`default_nettype none
package per_pkg;
  // Response latencies and master-abort windows, in bus clocks
  localparam int PERR_LAT_CONV = 2;
  localparam int PERR_LAT_PCIX = 3;
  localparam logic [2:0] DEVSEL_TO_CONV = 3'h5;
  localparam logic [2:0] DEVSEL_TO_PCIX = 3'h7;
  // Command register field positions
  localparam int CMD_PAR_RESP_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int PCIX_CMD_DPER_BIT = 0;
  // Status register field positions
  localparam int STS_DET_PAR_BIT = 15;
  localparam int STS_SERR_BIT = 14;
  localparam int STS_MST_ABORT_BIT = 13;
  localparam int STS_MST_PAR_BIT = 8;
  localparam int PCIX_STS_RCV_SPLIT_BIT = 29;
  // Split completion attribute and message codes
  localparam int SPLIT_ERR_ATTR_BIT = 30;
  localparam logic [3:0] SCM_CLASS_BRIDGE = 4'h1;
  localparam logic [7:0] SCM_INDEX_MST_ABORT = 8'h00;
  // IDE control block byte that is claimed
  localparam logic [1:0] IDE_ALT_OFFSET = 2'h2;
  // Reset value of all error flags
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  typedef struct packed {
    logic detPar;
    logic serrSet;
    logic mstAbort;
    logic mstPar;
    logic rcvScErr;
    logic dmaErr;
    logic dmaActive;
  } per_flags_t;

  typedef struct packed {
    logic wrParErr;
    logic rdCplParErr;
    logic scmParErr;
  } per_evt_t;

  typedef struct packed {
    logic attrValid;
    logic [31:0] attr;
    logic msgValid;
    logic [3:0] msgClass;
    logic [7:0] msgIndex;
    logic dataValid;
  } per_scm_t;

  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic addrParErr;
    logic [1:0] ctrlBarHit;
    logic [1:0] byteOff;
  } per_inb_t;

  typedef struct packed {
    logic fire;
    logic master;
  } per_perr_t;
endpackage
`default_nettype wire

/* logic/per_perr_delay.sv */
// Purpose: Delays a parity-error report to the PERR# slot after its data phase
// Assumes: At most one report per clock
// Notes: Output is registered and high for one clock
`default_nettype none
module per_perr_delay (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pcixMode,
  input wire per_pkg::per_perr_t evtIn,
  output per_pkg::per_perr_t evtOut
);
  import per_pkg::*;
  per_perr_t s1_q, s1_d, s2_q, s2_d, out_q, out_d;

  // Pick the tap so the output lands two or three clocks after the input
  always_comb begin
    s1_d = evtIn;
    s2_d = s1_q;
    out_d = (pcixMode) ? s2_q : s1_q;
  end

  // Pipeline registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      out_q <= out_d;
    end
  end

  assign evtOut = out_q;
endmodule
`default_nettype wire

/* logic/per_abort_timer.sv */
// Purpose: Watches DEVSEL# after FRAME# of an outbound transaction
// Assumes: frameStart is a one-clock pulse in the clock FRAME# is asserted
// Notes: timeout is a registered one-clock pulse
`default_nettype none
module per_abort_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pcixMode,
  input wire logic frameStart,
  input wire logic devselSeen,
  output logic timeout
);
  import per_pkg::*;
  logic active_q, active_d, tmo_q, tmo_d;
  logic [2:0] cnt_q, cnt_d;

  // Count clocks since FRAME# until DEVSEL# or the window ends
  always_comb begin
    active_d = active_q;
    cnt_d = cnt_q;
    tmo_d = 1'b0;
    if (frameStart) begin
      active_d = 1'b1;
      cnt_d = 3'h1;
    end else if (active_q) begin
      if (devselSeen) begin
        active_d = 1'b0;
      end else if (cnt_q == (pcixMode ? DEVSEL_TO_PCIX : DEVSEL_TO_CONV)) begin
        active_d = 1'b0;
        tmo_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  // Timer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      cnt_q <= 3'h0;
      tmo_q <= 1'b0;
    end else begin
      active_q <= active_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
    end
  end

  assign timeout = tmo_q;
endmodule
`default_nettype wire

/* logic/per_top.sv */
// Purpose: Error response of the PCI/PCI-X interface: PERR#, SERR#, DEVSEL# and error status
// Assumes: Bus decode delivers one-clock event pulses synchronous to core_clk
// Notes: Status is written one-to-clear; a set in the same clock wins
//
// What this block does
// - Bad parity reported on our inbound read data causes no action or status.
// - Write data parity error drives PERR# 2 clocks later, 3 in PCI-X, if enabled.
// - Write data parity error always sets detected parity error.
// - PCI-X read completion parity error drives PERR# 3 clocks later, if enabled.
// - That PERR# sets master parity error; detected parity error is always set.
// - Then SERR# and its status if SERR enabled and recover enable clear.
// - Read completion parity error sets DMA error and clears DMA active.
// - Split completion message with parity error is still accepted normally.
// - Split message parity error drives PERR# 3 clocks later, sets master parity.
// - Then SERR# and its status if SERR enabled and recover enable clear.
// - Attribute bit 30 set sets received split completion error status.
// - That status setting also sets detected parity, DMA error, clears DMA active.
// - No DEVSEL# within 5 clocks, 7 in PCI-X, of FRAME# is master abort.
// - PCI-X message class 1h index 00h is master abort of split read.
// - Any master abort sets status bit 13, DMA error, clears DMA active.
// - Master-aborted MSI write with SERR enable asserts SERR# and sets status.
// - Message-signalled master abort sets received split completion error bit.
// - Target master-aborts conventional address parity errors and PCI-X inbound reads.
// - Unsupported inbound commands never get DEVSEL#.
// - IDE control block is decoded through base address registers 1 and 3.
// - In the control block only byte 02H is claimed; others get no DEVSEL#.
`default_nettype none
module per_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pcixMode,
  input wire logic [15:0] pciCommandReg,
  input wire logic [15:0] pcixCommandReg,
  input wire logic pciStatusWr,
  input wire logic [15:0] pciStatusWrData,
  input wire logic pcixStatusWr,
  input wire logic [31:0] pcixStatusWrData,
  input wire logic dmaStart,
  input wire logic dmaErrClr,
  input wire per_pkg::per_evt_t evt,
  input wire logic inbRdParErrSeen,
  input wire per_pkg::per_scm_t scm,
  input wire logic frameStart,
  input wire logic devselSeen,
  input wire logic msiWrite,
  input wire per_pkg::per_inb_t inb,
  output logic [15:0] pciStatusReg,
  output logic [31:0] pcixStatusReg,
  output logic dmaErr,
  output logic dmaActive,
  output logic perrNOut,
  output logic perrOe,
  output logic serrNOut,
  output logic serrOe,
  output logic devselClaim,
  output logic ideAltSel,
  output logic scmAccept
);
  import per_pkg::*;

  per_flags_t flags_q, flags_d;
  per_perr_t perrIn, perrOut;
  logic serr_q, serr_d;
  logic parRespEn, serrEn, dperEn;
  logic maTimeout, msgAbort, maEvent, rcvScNew, serrReq;
  logic detParSet, dmaFail;

  // Commands 0,1,4,5,8,9 are not accepted by this target
  function automatic logic cmdSupported(input logic [3:0] c);
    cmdSupported = !(c == 4'h0 || c == 4'h1 || c == 4'h4 ||
                     c == 4'h5 || c == 4'h8 || c == 4'h9);
  endfunction

  // Read-type commands
  function automatic logic cmdIsRead(input logic [3:0] c);
    cmdIsRead = (c == 4'h2 || c == 4'h6 || c == 4'ha || c == 4'hc || c == 4'he);
  endfunction

  // Enables from the command registers
  assign parRespEn = pciCommandReg[CMD_PAR_RESP_BIT];
  assign serrEn = pciCommandReg[CMD_SERR_EN_BIT];
  assign dperEn = pcixCommandReg[PCIX_CMD_DPER_BIT];

  // Queue a PERR# report; enables are sampled at the data phase
  always_comb begin
    perrIn.fire = parRespEn & (evt.wrParErr |
                  (pcixMode & (evt.rdCplParErr | evt.scmParErr)));
    perrIn.master = evt.rdCplParErr | evt.scmParErr;
  end

  per_perr_delay uDelay (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pcixMode(pcixMode),
    .evtIn(perrIn),
    .evtOut(perrOut)
  );

  per_abort_timer uTimer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pcixMode(pcixMode),
    .frameStart(frameStart),
    .devselSeen(devselSeen),
    .timeout(maTimeout)
  );

  // Event decode; inbRdParErrSeen deliberately drives nothing
  always_comb begin
    msgAbort = pcixMode & scm.msgValid & (scm.msgClass == SCM_CLASS_BRIDGE) &
               (scm.msgIndex == SCM_INDEX_MST_ABORT);
    maEvent = maTimeout | msgAbort;
    rcvScNew = (scm.attrValid & scm.attr[SPLIT_ERR_ATTR_BIT]) | msgAbort;
    serrReq = (perrOut.fire & perrOut.master & serrEn & !dperEn) |
              (maTimeout & msiWrite & serrEn);
    detParSet = evt.wrParErr | evt.rdCplParErr | rcvScNew;
    dmaFail = evt.rdCplParErr | rcvScNew | maEvent;
  end

  // Status: software clears first, hardware sets override
  always_comb begin
    flags_d = flags_q;
    serr_d = serrReq;
    if (pciStatusWr) begin
      if (pciStatusWrData[STS_DET_PAR_BIT]) flags_d.detPar = 1'b0;
      if (pciStatusWrData[STS_SERR_BIT]) flags_d.serrSet = 1'b0;
      if (pciStatusWrData[STS_MST_ABORT_BIT]) flags_d.mstAbort = 1'b0;
      if (pciStatusWrData[STS_MST_PAR_BIT]) flags_d.mstPar = 1'b0;
    end
    if (pcixStatusWr && pcixStatusWrData[PCIX_STS_RCV_SPLIT_BIT]) flags_d.rcvScErr = 1'b0;
    if (dmaErrClr) flags_d.dmaErr = 1'b0;
    if (dmaStart) flags_d.dmaActive = 1'b1;
    if (detParSet) flags_d.detPar = 1'b1;
    if (perrOut.fire && perrOut.master) flags_d.mstPar = 1'b1;
    if (serrReq) flags_d.serrSet = 1'b1;
    if (maEvent) flags_d.mstAbort = 1'b1;
    if (rcvScNew) flags_d.rcvScErr = 1'b1;
    if (dmaFail) begin
      flags_d.dmaErr = 1'b1;
      flags_d.dmaActive = 1'b0;
    end
  end

  // Status and SERR# registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RESET;
      serr_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      serr_q <= serr_d;
    end
  end

  // Status words as software sees them
  always_comb begin
    pciStatusReg = 16'h0000;
    pciStatusReg[STS_DET_PAR_BIT] = flags_q.detPar;
    pciStatusReg[STS_SERR_BIT] = flags_q.serrSet;
    pciStatusReg[STS_MST_ABORT_BIT] = flags_q.mstAbort;
    pciStatusReg[STS_MST_PAR_BIT] = flags_q.mstPar;
    pcixStatusReg = 32'h0000_0000;
    pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT] = flags_q.rcvScErr;
  end
  assign dmaErr = flags_q.dmaErr;
  assign dmaActive = flags_q.dmaActive;

  // PERR# and SERR# pins; SERR# is open drain
  assign perrNOut = ~perrOut.fire;
  assign perrOe = perrOut.fire;
  assign serrNOut = 1'b0;
  assign serrOe = serr_q;

  // Target decode: claim only legal accesses
  always_comb begin
    ideAltSel = inb.valid & (|inb.ctrlBarHit) & (inb.byteOff == IDE_ALT_OFFSET);
    devselClaim = inb.valid & cmdSupported(inb.cmd) &
                  !(!pcixMode & inb.addrParErr) &
                  !(pcixMode & cmdIsRead(inb.cmd)) &
                  !((|inb.ctrlBarHit) & (inb.byteOff != IDE_ALT_OFFSET));
  end

  // Split completion data is always taken, parity error or not
  assign scmAccept = scm.dataValid;

  // Checks
  a_perr_conv_lat: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!pcixMode && parRespEn && evt.wrParErr) ##1 !pcixMode ##1 !pcixMode |-> perrOe)
    else $error("PERR# missing two clocks after write parity error");
  a_perr_pcix_lat: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pcixMode && parRespEn && evt.rdCplParErr) ##1 pcixMode [*3] |-> perrOe && !perrNOut)
    else $error("PERR# missing three clocks after completion parity error");
  a_perr_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!parRespEn && evt.wrParErr && !evt.rdCplParErr && !evt.scmParErr) ##1
    !perrIn.fire [*2] |-> ##1 !perrOe)
    else $error("PERR# driven while parity response disabled");
  a_det_par_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    evt.wrParErr |=> pciStatusReg[STS_DET_PAR_BIT])
    else $error("Detected parity not set on write parity error");
  a_mst_par_perr: assert property (@(posedge core_clk) disable iff (!rst_n)
    perrOe && !$past(evt.wrParErr, 2) && !$past(evt.wrParErr, 3) |=>
    pciStatusReg[STS_MST_PAR_BIT])
    else $error("Master parity not set with PERR#");
  a_serr_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    serrOe |-> $past(serrEn) && pciStatusReg[STS_SERR_BIT])
    else $error("SERR# without enable or status");
  a_dma_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
    evt.rdCplParErr |=> dmaErr && !dmaActive)
    else $error("DMA not halted on completion parity error");
  a_split_err_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    scm.attrValid && scm.attr[SPLIT_ERR_ATTR_BIT] |=>
    pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT] && pciStatusReg[STS_DET_PAR_BIT] && dmaErr)
    else $error("Split completion error attribute not recorded");
  a_ma_conv_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameStart && !pcixMode ##1 (!devselSeen && !frameStart && !pcixMode) [*5] |=>
    ##1 (pciStatusReg[STS_MST_ABORT_BIT] && dmaErr))
    else $error("Master abort not taken after five clocks");
  a_ma_msg: assert property (@(posedge core_clk) disable iff (!rst_n)
    msgAbort |=> pciStatusReg[STS_MST_ABORT_BIT] && pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT])
    else $error("Master abort message not recorded");
  a_ide_offset: assert property (@(posedge core_clk) disable iff (!rst_n)
    inb.valid && (|inb.ctrlBarHit) && inb.byteOff != IDE_ALT_OFFSET |-> !devselClaim)
    else $error("IDE control block byte other than 02H claimed");
  a_unsup_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    inb.valid && !cmdSupported(inb.cmd) |-> !devselClaim)
    else $error("Unsupported command claimed");
  a_status_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    pciStatusReg[STS_MST_ABORT_BIT] && !pciStatusWr |=> pciStatusReg[STS_MST_ABORT_BIT])
    else $error("Master abort status lost without a clear");

  c_perr_serr: cover property (@(posedge core_clk) disable iff (!rst_n) perrOe ##1 serrOe);
  c_ma_timeout: cover property (@(posedge core_clk) disable iff (!rst_n) maTimeout);
  c_ide_claim: cover property (@(posedge core_clk) disable iff (!rst_n) ideAltSel && devselClaim);
  c_split_abort: cover property (@(posedge core_clk) disable iff (!rst_n) msgAbort);
  c_wr_perr: cover property (@(posedge core_clk) disable iff (!rst_n) evt.wrParErr ##2 perrOe);

  // Read data parity reported by the initiator leaves status alone
  a_rd_par_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    inbRdParErrSeen && !detParSet && !maEvent && !perrOut.fire && !pciStatusWr &&
    !pcixStatusWr |=> $stable(pciStatusReg) && $stable(pcixStatusReg))
    else $error("Status changed on reported read data parity");

  // PERR# in PCI-X mode, and none for completions in conventional mode
  a_perr_pcix_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pcixMode && parRespEn && evt.wrParErr) ##1 pcixMode [*3] |-> perrOe)
    else $error("PERR# missing three clocks after PCI-X write parity error");
  a_perr_scm_lat: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pcixMode && parRespEn && evt.scmParErr) ##1 pcixMode [*3] |->
    perrOe ##1 pciStatusReg[STS_MST_PAR_BIT])
    else $error("PERR# or master parity missing after message parity error");
  a_no_perr_conv: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!pcixMode && !evt.wrParErr && (evt.rdCplParErr || evt.scmParErr)) ##1 !pcixMode |=>
    !perrOe)
    else $error("PERR# driven for a completion in conventional mode");

  // SERR# only where enabled
  a_serr_msi: assert property (@(posedge core_clk) disable iff (!rst_n)
    maTimeout && msiWrite && serrEn |=> serrOe && pciStatusReg[STS_SERR_BIT])
    else $error("SERR# missing on master-aborted MSI write");
  a_no_serr_plain: assert property (@(posedge core_clk) disable iff (!rst_n)
    maTimeout && !msiWrite && !(perrOut.fire && perrOut.master) |=> !serrOe)
    else $error("SERR# on master abort of a plain write");
  a_serr_recover_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    perrOut.fire && dperEn && !(maTimeout && msiWrite) |=> !serrOe)
    else $error("SERR# driven with recover enable set");

  // DMA halt and sticky status
  a_dma_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    maEvent |=> pciStatusReg[STS_MST_ABORT_BIT] && dmaErr && !dmaActive)
    else $error("Master abort did not halt DMA");
  a_rcv_split_det: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT]) |->
    pciStatusReg[STS_DET_PAR_BIT] && dmaErr && !dmaActive)
    else $error("Split error status set without its side effects");
  a_det_par_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    pciStatusReg[STS_DET_PAR_BIT] && !pciStatusWr |=> pciStatusReg[STS_DET_PAR_BIT])
    else $error("Detected parity status lost without a clear");
  a_mst_par_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    pciStatusReg[STS_MST_PAR_BIT] && !pciStatusWr |=> pciStatusReg[STS_MST_PAR_BIT])
    else $error("Master parity status lost without a clear");
  a_rcv_split_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT] && !pcixStatusWr |=>
    pcixStatusReg[PCIX_STS_RCV_SPLIT_BIT])
    else $error("Split error status lost without a clear");
  a_dma_err_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    dmaErr && !dmaErrClr |=> dmaErr)
    else $error("DMA error lost without a clear");

  // PCI-X master abort window
  a_ma_pcix_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameStart && pcixMode ##1 (!devselSeen && !frameStart && pcixMode) [*7] |=>
    ##1 (pciStatusReg[STS_MST_ABORT_BIT] && dmaErr))
    else $error("Master abort not taken after seven clocks");

  // Target decode and split completion data
  a_scm_accept: assert property (@(posedge core_clk) disable iff (!rst_n)
    scm.dataValid |-> scmAccept)
    else $error("Split completion data refused");
  a_pcix_rd_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    inb.valid && pcixMode && cmdIsRead(inb.cmd) |-> !devselClaim)
    else $error("PCI-X inbound read claimed");
  a_addr_par_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    inb.valid && !pcixMode && inb.addrParErr |-> !devselClaim)
    else $error("Address parity error access claimed");
  a_ide_alt_claim: assert property (@(posedge core_clk) disable iff (!rst_n)
    inb.valid && (|inb.ctrlBarHit) && inb.byteOff == IDE_ALT_OFFSET && !pcixMode &&
    !inb.addrParErr && cmdSupported(inb.cmd) |-> devselClaim && ideAltSel)
    else $error("IDE control block byte 02H not claimed");
endmodule
`default_nettype wire

/* verif/per_bus_partner.sv */
// Purpose: Far side of the bus: a target that claims with DEVSEL# and an initiator
// Assumes: devselDelay of zero means that no target ever claims the transaction
// Notes: DEVSEL# is released sixteen clocks after FRAME#; idle level is deasserted
`default_nettype none
module per_bus_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic frameStart,
  input wire logic [3:0] devselDelay,
  input wire logic reportBad,
  output logic devselSeen,
  output logic inbRdParErrSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] clkCount_q;
  logic report_q;
  // Count clocks since FRAME#, restart on every new transaction
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkCount_q <= 4'h0;
      report_q <= 1'b0;
    end else begin
      clkCount_q <= frameStart ? 4'h1 : (clkCount_q == 4'h0 || clkCount_q == 4'hf) ? 4'h0 :
        clkCount_q + 4'h1;
      report_q <= reportBad;
    end
  end
  // Claim from the chosen clock until the window closes, then release
  assign devselSeen = (devselDelay != 4'h0) && (clkCount_q != 4'h0) &&
    (clkCount_q >= devselDelay);
  // Initiator reports bad parity on read data it received
  assign inbRdParErrSeen = report_q;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench of the error-response block
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes: obs packs status bits, DMA flags and pin drivers into one word
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import per_pkg::*;
  logic core_clk, rst_n, pcixMode, pciStatusWr, pcixStatusWr, dmaStart, dmaErrClr;
  logic frameStart, devselSeen, msiWrite, inbRdParErrSeen, reportBad;
  logic [15:0] pciCommandReg, pcixCommandReg, pciStatusWrData, pciStatusReg;
  logic [31:0] pcixStatusWrData, pcixStatusReg;
  logic [3:0] devselDelay;
  per_evt_t evt;
  per_scm_t scm;
  per_inb_t inb;
  logic dmaErr, dmaActive, perrNOut, perrOe, serrNOut, serrOe, devselClaim, ideAltSel, scmAccept;
  int failures = 0, check_count = 0, cycles = 0;
  // Observed word: rcvSplit detPar serrSet mstAbort mstPar dmaErr dmaActive perrOe perrN serrOe
  wire logic [9:0] obs = {pcixStatusReg[29], pciStatusReg[15:13], pciStatusReg[8], dmaErr,
    dmaActive, perrOe, perrNOut, serrOe};

  per_top per_top_inst (.core_clk, .rst_n, .pcixMode, .pciCommandReg, .pcixCommandReg,
    .pciStatusWr, .pciStatusWrData, .pcixStatusWr, .pcixStatusWrData, .dmaStart, .dmaErrClr,
    .evt, .inbRdParErrSeen, .scm, .frameStart, .devselSeen, .msiWrite, .inb, .pciStatusReg,
    .pcixStatusReg, .dmaErr, .dmaActive, .perrNOut, .perrOe, .serrNOut, .serrOe, .devselClaim,
    .ideAltSel, .scmAccept);
  per_bus_partner per_bus_partner_inst (.core_clk, .rst_n, .frameStart, .devselDelay,
    .reportBad, .devselSeen, .inbRdParErrSeen);

  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Clear all status, pick mode and enables, restart DMA, confirm the clean state
  task automatic setup(input logic mode, input logic [15:0] cmd, input logic [15:0] xcmd,
      input logic msi, input logic [3:0] dly);
    @(posedge core_clk);
    pcixMode <= mode;
    pciCommandReg <= cmd;
    pcixCommandReg <= xcmd;
    msiWrite <= msi;
    devselDelay <= dly;
    pciStatusWrData <= 16'he100;
    pcixStatusWrData <= 32'h20000000;
    {pciStatusWr, pcixStatusWr, dmaErrClr, dmaStart} <= 4'hf;
    @(posedge core_clk);
    {pciStatusWr, pcixStatusWr, dmaErrClr, dmaStart} <= 4'h0;
    @(posedge core_clk);
    #1 chk("cleared", obs, 10'h00a);
  endtask

  // One-clock event pulse; returns at the edge that takes it
  task automatic fire(input per_evt_t e, input per_scm_t s, input logic fs);
    @(posedge core_clk);
    evt <= e;
    scm <= s;
    frameStart <= fs;
    #1 chk("accept", {9'h000, scmAccept}, {9'h000, s.dataValid});
    @(posedge core_clk);
    evt <= '0;
    scm <= '0;
    frameStart <= 1'b0;
  endtask

  // Compare four consecutive clocks after an optional wait
  task automatic watch(input string nm, input int skip, input logic [9:0] mask,
      input logic [9:0] e [4]);
    repeat (skip) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      #1 chk(nm, obs & mask, e[i]);
    end
    $display("test %s done", nm);
  endtask

  task automatic dec(input logic mode, input per_inb_t i, input logic [1:0] exp);
    @(posedge core_clk);
    pcixMode <= mode;
    inb <= i;
    #1 chk("decode", {8'h00, devselClaim, ideAltSel}, {8'h00, exp});
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {pcixMode, pciStatusWr, pcixStatusWr, dmaStart, dmaErrClr, frameStart, msiWrite} = 7'h00;
    reportBad = 1'b0;
    {pciCommandReg, pcixCommandReg, pciStatusWrData, pcixStatusWrData} = 80'h0;
    {evt, scm, inb} = '0;
    devselDelay = 4'h0;
    repeat (6) @(posedge core_clk);
    #1 chk("reset", obs, 10'h002);
    @(posedge core_clk);
    rst_n <= 1'b1;
    setup(1'b0, 16'h0040, 16'h0000, 1'b0, 4'h0);
    fire(3'h4, '0, 1'b0);
    watch("wr conv", 0, 10'h3ff, '{10'h10c, 10'h10a, 10'h10a, 10'h10a});
    setup(1'b1, 16'h0040, 16'h0000, 1'b0, 4'h0);
    fire(3'h4, '0, 1'b0);
    watch("wr pcix", 0, 10'h3ff, '{10'h10a, 10'h10c, 10'h10a, 10'h10a});
    setup(1'b0, 16'h0000, 16'h0000, 1'b0, 4'h0);
    fire(3'h4, '0, 1'b0);
    watch("wr noresp", 0, 10'h3ff, '{4{10'h10a}});
    setup(1'b1, 16'h0140, 16'h0000, 1'b0, 4'h0);
    fire(3'h2, '0, 1'b0);
    watch("rdcpl serr", 0, 10'h3ff, '{10'h112, 10'h114, 10'h1b3, 10'h1b2});
    setup(1'b1, 16'h0140, 16'h0001, 1'b0, 4'h0);
    fire(3'h2, '0, 1'b0);
    watch("rdcpl recover", 0, 10'h3ff, '{10'h112, 10'h114, 10'h132, 10'h132});
    setup(1'b1, 16'h0140, 16'h0000, 1'b0, 4'h0);
    fire(3'h1, '{1'b0, 32'h0, 1'b0, 4'h0, 8'h00, 1'b1}, 1'b0);
    watch("scm perr", 0, 10'h0a7, '{10'h002, 10'h004, 10'h0a3, 10'h0a2});
    setup(1'b1, 16'h0040, 16'h0000, 1'b0, 4'h0);
    fire(3'h0, '{1'b1, 32'hbfffffff, 1'b0, 4'h0, 8'h00, 1'b0}, 1'b0);
    watch("attr plain", 0, 10'h3ff, '{4{10'h00a}});
    fire(3'h0, '{1'b1, 32'h40000000, 1'b0, 4'h0, 8'h00, 1'b0}, 1'b0);
    watch("split err attr", 0, 10'h3ff, '{4{10'h312}});
    setup(1'b1, 16'h0040, 16'h0000, 1'b0, 4'h0);
    fire(3'h0, '{1'b0, 32'h0, 1'b1, 4'h0, 8'h00, 1'b0}, 1'b0);
    watch("msg other", 0, 10'h3ff, '{4{10'h00a}});
    fire(3'h0, '{1'b0, 32'h0, 1'b1, 4'h1, 8'h00, 1'b0}, 1'b0);
    watch("msg abort", 0, 10'h3ff, '{4{10'h352}});
    setup(1'b0, 16'h0140, 16'h0000, 1'b1, 4'h5);
    fire(3'h0, '0, 1'b1);
    watch("devsel late ok", 4, 10'h3ff, '{4{10'h00a}});
    setup(1'b0, 16'h0140, 16'h0000, 1'b1, 4'h6);
    fire(3'h0, '0, 1'b1);
    watch("abort msi", 4, 10'h37f, '{10'h00a, 10'h053, 10'h052, 10'h052});
    chk("abort serr", obs, 10'h0d2);
    chk("serr pin", {9'h000, serrNOut}, 10'h000);
    setup(1'b1, 16'h0140, 16'h0000, 1'b0, 4'h0);
    fire(3'h0, '0, 1'b1);
    watch("abort pcix", 6, 10'h3ff, '{10'h00a, 10'h052, 10'h052, 10'h052});
    setup(1'b1, 16'h0140, 16'h0000, 1'b0, 4'h0);
    @(posedge core_clk);
    reportBad <= 1'b1;
    @(posedge core_clk);
    reportBad <= 1'b0;
    watch("rd data", 0, 10'h3ff, '{4{10'h00a}});
    dec(1'b0, '{1'b1, 4'h7, 1'b0, 2'h0, 2'h0}, 2'h2);
    dec(1'b0, '{1'b1, 4'h0, 1'b0, 2'h0, 2'h0}, 2'h0);
    dec(1'b0, '{1'b1, 4'h7, 1'b1, 2'h0, 2'h0}, 2'h0);
    dec(1'b1, '{1'b1, 4'h6, 1'b0, 2'h0, 2'h0}, 2'h0);
    dec(1'b1, '{1'b1, 4'h7, 1'b0, 2'h0, 2'h0}, 2'h2);
    dec(1'b0, '{1'b1, 4'h3, 1'b0, 2'h1, 2'h2}, 2'h3);
    for (int b = 0; b < 4; b++) begin
      dec(1'b0, '{1'b1, 4'h3, 1'b0, 2'h2, b[1:0]}, {2{b == 2}});
    end
    $display("test decode done");
    test_done();
  end
endmodule
`default_nettype wire
